// File: laser_drive_fault_control.sv
// Laser drive mode, power-down gating, fault latch and self-test with an APB register file.
// Overview of operation
// RULE_01: Two drive modes, continuous and shutter, selected by one configuration flag bit.
// RULE_02: Continuous mode keeps drive on always except during power-down; the code also stops drive during a fault and while the self-test runs.
// RULE_03: Shutter mode drives only during the illuminated part of each frame.
// RULE_04: Mode bit resets to shutter; firmware keeps shutter except calibration.
// RULE_05: Supply enable output is held low in fault-free operation.
// RULE_06: Ground short at current-set or drive pin stops drive, raises supply enable.
// RULE_07: Each write of the low power register launches a ground, supply, detector test.
// RULE_08: Firmware selects continuous mode before programming both power registers.
// RULE_09: Power-down starts within one frame period plus 100 us after the pin falls.
// RULE_10: A detected fault persists until hardware reset.
//
// The address map and the APB interface to the registers were decided locally.
module laser_drive_fault_control
  import laser_ctrl_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        NRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        POWER_DOWN_N,
  input  wire logic        SET_PIN_GND,
  input  wire logic        DRIVE_PIN_GND,
  input  wire logic        DRIVE_PIN_VDD,
  output logic             DRIVE_CURRENT_OUTPUT,
  output logic             SUPPLY_ENABLE_N,
  output logic             DETECTOR_PROBE
);

  logic [3:0]  pins_sync;
  logic        pd_n_s;
  logic        set_gnd_s;
  logic        drv_gnd_s;
  logic        drv_vdd_s;

  logic        mode;
  logic        next_mode;
  logic [7:0]  power_cfg_low;
  logic [7:0]  next_power_cfg_low;
  logic [7:0]  power_cfg_high;
  logic [7:0]  next_power_cfg_high;
  logic [15:0] frame_period;
  logic [15:0] next_frame_period;
  logic [15:0] illum_cycles;
  logic [15:0] next_illum_cycles;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  logic [15:0] frame_cnt;
  logic [15:0] next_frame_cnt;
  logic        pd_pending;
  logic        next_pd_pending;
  logic        pdown;
  logic        next_pdown;
  logic        pd_n_prev;
  logic        next_pd_n_prev;
  logic [13:0] margin_cnt;
  logic [13:0] next_margin_cnt;

  logic        fault;
  logic        next_fault;
  logic        gnd_seen;
  logic        next_gnd_seen;
  logic        vdd_seen;
  logic        next_vdd_seen;
  test_state_t test_state;
  test_state_t next_test_state;
  logic [4:0]  step_cnt;
  logic [4:0]  next_step_cnt;
  logic        next_drive;
  logic        next_supply_n;
  logic        next_probe;
  logic        wr_en;
  logic        rd_en;
  logic [1:0]  probe_dly;
  logic [1:0]  next_probe_dly;
  logic        drv_gnd_live;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  laser_sync #(.WIDTH(4)) u_sync (
    .clk       (SYS_CLK),
    .rst_n     (NRST),
    .async_in  ({DRIVE_PIN_VDD, DRIVE_PIN_GND, SET_PIN_GND, POWER_DOWN_N}),
    .reset_val (4'h0),
    .sync_out  (pins_sync)
  );

  assign pd_n_s    = pins_sync[0];
  assign set_gnd_s = pins_sync[1];
  assign drv_gnd_s = pins_sync[2];
  assign drv_vdd_s = pins_sync[3];

  assign wr_en = PSEL && PENABLE && PWRITE && PREADY;
  assign rd_en = PSEL && !PENABLE && !PWRITE;

  // APB slave: no wait states, reads are prepared in the setup cycle.
  always_comb begin
    next_mode           = mode;
    next_power_cfg_low  = power_cfg_low;
    next_power_cfg_high = power_cfg_high;
    next_frame_period   = frame_period;
    next_illum_cycles   = illum_cycles;
    next_prdata         = PRDATA;
    next_pready         = PSEL && !PENABLE;
    next_pslverr        = 1'b0;
    if (rd_en) begin
      next_prdata = 32'h0000_0000;
      if (addr_hit(PADDR, ADDR_CFG_FLAGS)) begin
        next_prdata[MODE_BIT] = mode;
      end else if (addr_hit(PADDR, ADDR_POWER_CFG_LOW)) begin
        next_prdata[7:0] = power_cfg_low;
      end else if (addr_hit(PADDR, ADDR_POWER_CFG_HIGH)) begin
        next_prdata[7:0] = power_cfg_high;
      end else if (addr_hit(PADDR, ADDR_STATUS)) begin
        next_prdata[ST_DRIVE_BIT] = DRIVE_CURRENT_OUTPUT;
        next_prdata[ST_FAULT_BIT] = fault;
        next_prdata[ST_PDOWN_BIT] = pdown;
        next_prdata[ST_TEST_BIT]  = test_state != TEST_IDLE;
        next_prdata[ST_GND_BIT]   = gnd_seen;
        next_prdata[ST_VDD_BIT]   = vdd_seen;
      end else if (addr_hit(PADDR, ADDR_FRAME_PERIOD)) begin
        next_prdata[15:0] = frame_period;
      end else if (addr_hit(PADDR, ADDR_ILLUM_CYCLES)) begin
        next_prdata[15:0] = illum_cycles;
      end else begin
        next_pslverr = 1'b1;
      end
    end else if (PSEL && !PENABLE) begin
      next_pslverr = !(addr_hit(PADDR, ADDR_CFG_FLAGS) || addr_hit(PADDR, ADDR_POWER_CFG_LOW) ||
                       addr_hit(PADDR, ADDR_POWER_CFG_HIGH) || addr_hit(PADDR, ADDR_STATUS) ||
                       addr_hit(PADDR, ADDR_FRAME_PERIOD) || addr_hit(PADDR, ADDR_ILLUM_CYCLES));
    end
    if (wr_en) begin
      if (addr_hit(PADDR, ADDR_CFG_FLAGS)) begin
        next_mode = PWDATA[MODE_BIT]; // [RULE_01]
      end
      if (addr_hit(PADDR, ADDR_POWER_CFG_LOW)) begin
        next_power_cfg_low = PWDATA[7:0];
      end
      if (addr_hit(PADDR, ADDR_POWER_CFG_HIGH)) begin
        next_power_cfg_high = PWDATA[7:0];
      end
      if (addr_hit(PADDR, ADDR_FRAME_PERIOD) && PWDATA[15:0] != 16'h0000) begin
        next_frame_period = PWDATA[15:0];
      end
      if (addr_hit(PADDR, ADDR_ILLUM_CYCLES)) begin
        next_illum_cycles = PWDATA[15:0];
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      mode           <= MODE_SHUTTER; // [RULE_04]
      power_cfg_low  <= POWER_CFG_RESET;
      power_cfg_high <= POWER_CFG_RESET;
      frame_period   <= FRAME_PERIOD_RESET;
      illum_cycles   <= ILLUM_CYCLES_RESET;
      PRDATA         <= 32'h0000_0000;
      PREADY         <= 1'b0;
      PSLVERR        <= 1'b0;
    end else begin
      mode           <= next_mode;
      power_cfg_low  <= next_power_cfg_low;
      power_cfg_high <= next_power_cfg_high;
      frame_period   <= next_frame_period;
      illum_cycles   <= next_illum_cycles;
      PRDATA         <= next_prdata;
      PREADY         <= next_pready;
      PSLVERR        <= next_pslverr;
    end
  end

  // Frame timing and power-down entry, taken at the end of the current frame plus a margin.
  always_comb begin
    next_frame_cnt  = (frame_cnt + 16'h0001 >= frame_period) ? 16'h0000 : frame_cnt + 16'h0001;
    next_pd_n_prev  = pd_n_s;
    next_pd_pending = pd_pending;
    next_pdown      = pdown;
    next_margin_cnt = margin_cnt;
    if (pd_n_s) begin
      next_pd_pending = 1'b0;
      next_pdown      = 1'b0;
      next_margin_cnt = 14'h0000;
    end else if (pd_n_prev && !pdown) begin
      next_pd_pending = 1'b1;
    end else if (pd_pending && margin_cnt >= 14'(PD_MARGIN_CYC - 1)) begin
      // The margin starts at the frame wrap and ends power-down entry on its own.
      next_pdown      = 1'b1; // [RULE_09]
      next_pd_pending = 1'b0;
    end
    if (pd_pending && (frame_cnt == 16'h0000 || margin_cnt != 14'h0000) && !next_pdown) begin
      next_margin_cnt = margin_cnt + 14'h0001;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      frame_cnt  <= 16'h0000;
      pd_n_prev  <= 1'b0;
      pd_pending <= 1'b0;
      pdown      <= 1'b0;
      margin_cnt <= 14'h0000;
    end else begin
      frame_cnt  <= next_frame_cnt;
      pd_n_prev  <= next_pd_n_prev;
      pd_pending <= next_pd_pending;
      pdown      <= next_pdown;
      margin_cnt <= next_margin_cnt;
    end
  end

  // Fault latch, self-test sequencer and drive outputs.
  always_comb begin
    next_fault      = fault;
    next_gnd_seen   = gnd_seen;
    next_vdd_seen   = vdd_seen;
    next_test_state = test_state;
    next_step_cnt   = step_cnt + 5'h01;
    next_probe      = 1'b0;
    next_probe_dly  = {probe_dly[0], DETECTOR_PROBE};
    // The detector's own answer to the probe reaches us two cycles late; it is not a short.
    drv_gnd_live    = drv_gnd_s && !DETECTOR_PROBE && (probe_dly == 2'b00);
    if (set_gnd_s || drv_gnd_live) begin
      next_fault    = 1'b1; // [RULE_06] [RULE_10]
      next_gnd_seen = next_gnd_seen | drv_gnd_live;
    end
    if (wr_en && addr_hit(PADDR, ADDR_POWER_CFG_LOW)) begin
      next_test_state = TEST_GND; // [RULE_07]
      next_step_cnt   = 5'h00;
    end else if (step_cnt == 5'(TEST_STEP_CYC - 1)) begin
      next_step_cnt = 5'h00;
      unique case (test_state)
        TEST_IDLE: begin
          next_step_cnt = step_cnt;
        end
        TEST_GND: begin
          if (drv_gnd_s) begin
            next_fault = 1'b1; // [RULE_07]
          end
          next_test_state = TEST_VDD;
        end
        TEST_VDD: begin
          if (drv_vdd_s) begin
            next_fault    = 1'b1; // [RULE_07]
            next_vdd_seen = 1'b1;
          end
          next_test_state = TEST_DETECTOR;
        end
        TEST_DETECTOR: begin
          // The probe pulls the drive pin low; a healthy detector reports ground.
          if (!drv_gnd_s) begin
            next_fault = 1'b1; // [RULE_07]
          end
          next_test_state = TEST_IDLE;
        end
      endcase
    end else if (test_state == TEST_IDLE) begin
      next_step_cnt = step_cnt;
    end
    if (next_test_state == TEST_DETECTOR) begin
      next_probe = 1'b1;
    end
    next_supply_n = next_fault; // [RULE_05] [RULE_06]
    if (next_fault || pdown || next_test_state != TEST_IDLE) begin
      next_drive = 1'b0; // [RULE_02] [RULE_10]
    end else if (mode == MODE_CONTINUOUS) begin
      next_drive = 1'b1; // [RULE_02]
    end else begin
      next_drive = next_frame_cnt < illum_cycles; // [RULE_03]
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      fault                <= 1'b0;
      gnd_seen             <= 1'b0;
      vdd_seen             <= 1'b0;
      test_state           <= TEST_IDLE;
      step_cnt             <= 5'h00;
      probe_dly            <= 2'b00;
      DRIVE_CURRENT_OUTPUT <= 1'b0;
      SUPPLY_ENABLE_N      <= 1'b0;
      DETECTOR_PROBE       <= 1'b0;
    end else begin
      fault                <= next_fault;
      gnd_seen             <= next_gnd_seen;
      vdd_seen             <= next_vdd_seen;
      test_state           <= next_test_state;
      step_cnt             <= next_step_cnt;
      probe_dly            <= next_probe_dly;
      DRIVE_CURRENT_OUTPUT <= next_drive;
      SUPPLY_ENABLE_N      <= next_supply_n;
      DETECTOR_PROBE       <= next_probe;
    end
  end

endmodule

// File: laser_ctrl_pkg.sv
// Package with register map, field positions and timing constants for the laser drive control.
package laser_ctrl_pkg;

  localparam logic [7:0]  ADDR_CFG_FLAGS     = 8'h00;
  localparam logic [7:0]  ADDR_POWER_CFG_LOW = 8'h04;
  localparam logic [7:0]  ADDR_POWER_CFG_HIGH = 8'h08;
  localparam logic [7:0]  ADDR_STATUS        = 8'h0C;
  localparam logic [7:0]  ADDR_FRAME_PERIOD  = 8'h10;
  localparam logic [7:0]  ADDR_ILLUM_CYCLES  = 8'h14;

  localparam int          MODE_BIT           = 0;
  localparam logic        MODE_SHUTTER       = 1'b0;
  localparam logic        MODE_CONTINUOUS    = 1'b1;

  localparam int          ST_DRIVE_BIT       = 0;
  localparam int          ST_FAULT_BIT       = 1;
  localparam int          ST_PDOWN_BIT       = 2;
  localparam int          ST_TEST_BIT        = 3;
  localparam int          ST_GND_BIT         = 4;
  localparam int          ST_VDD_BIT         = 5;

  localparam logic [7:0]  POWER_CFG_RESET    = 8'h00;
  localparam logic [15:0] FRAME_PERIOD_RESET = 16'hC350;
  localparam logic [15:0] ILLUM_CYCLES_RESET = 16'h1388;

  localparam int          CLK_MHZ            = 100;
  localparam int          PD_MARGIN_US       = 100;
  localparam int          PD_MARGIN_CYC      = PD_MARGIN_US * CLK_MHZ;
  localparam int          TEST_STEP_CYC      = 16;

  typedef enum logic [1:0] {
    TEST_IDLE,
    TEST_GND,
    TEST_VDD,
    TEST_DETECTOR
  } test_state_t;

endpackage

// File: laser_sync.sv
// Two flip-flop synchroniser bank for asynchronous pin inputs.
module laser_sync
  import laser_ctrl_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_val,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  always_comb begin
    next_stage1   = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule

// File: laser_ctrl_checker_assertions.sv
// Concurrent checks on the ports of the laser drive control block.
module laser_ctrl_checker
  import laser_ctrl_pkg::*;
(
  input logic       SYS_CLK,
  input logic       NRST,
  input logic       PSEL,
  input logic       PENABLE,
  input logic       PWRITE,
  input logic [7:0] PADDR,
  input logic       PREADY,
  input logic       PSLVERR,
  input logic       SET_PIN_GND,
  input logic       DRIVE_PIN_GND,
  input logic       DRIVE_CURRENT_OUTPUT,
  input logic       SUPPLY_ENABLE_N,
  input logic       DETECTOR_PROBE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  chk_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  chk_ready_one_cycle: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  chk_error_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  chk_fault_sticky: assert property (SUPPLY_ENABLE_N |=> SUPPLY_ENABLE_N)
    else $error("fault state cleared");
  chk_fault_drive_off: assert property (SUPPLY_ENABLE_N |=> !DRIVE_CURRENT_OUTPUT)
    else $error("drive on after fault");
  chk_ground_short: assert property ((SET_PIN_GND || (DRIVE_PIN_GND && !DETECTOR_PROBE))
    |-> ##[1:5] SUPPLY_ENABLE_N)
    else $error("short not reported");
  chk_test_launch: assert property (PSEL && PENABLE && PREADY && PWRITE && !SUPPLY_ENABLE_N
    && PADDR == ADDR_POWER_CFG_LOW |-> ##[1:60] DETECTOR_PROBE)
    else $error("self test not launched");
  chk_probe_drive_off: assert property (DETECTOR_PROBE |-> !DRIVE_CURRENT_OUTPUT)
    else $error("drive on during probe");
  cover property ($rose(SUPPLY_ENABLE_N));
  cover property ($rose(DETECTOR_PROBE));
  cover property (PSLVERR);
endmodule

bind laser_drive_fault_control laser_ctrl_checker chk_u (.SYS_CLK(SYS_CLK), .NRST(NRST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .SET_PIN_GND(SET_PIN_GND), .DRIVE_PIN_GND(DRIVE_PIN_GND),
  .DRIVE_CURRENT_OUTPUT(DRIVE_CURRENT_OUTPUT), .SUPPLY_ENABLE_N(SUPPLY_ENABLE_N),
  .DETECTOR_PROBE(DETECTOR_PROBE));

// File: laser_load_model.sv
// Model of the laser diode, its supply switch and the pin shorts.
module laser_load_model (
  input  logic drive,
  input  logic supply_enable_n,
  input  logic short_set,
  input  logic short_gnd,
  input  logic short_vdd,
  input  logic probe,
  output logic set_gnd,
  output logic pin_gnd,
  output logic pin_vdd,
  output logic lit
);
  timeunit 1ns;
  timeprecision 1ps;
  // A healthy detector pulls the drive pin to ground while probed.
  assign set_gnd = short_set;
  assign pin_gnd = short_gnd | probe;
  assign pin_vdd = short_vdd;
  assign lit = drive & ~supply_enable_n;
endmodule

// File: tb_laser_drive_fault_control.sv
// Self-checking bench for the laser drive and fault control block.
module tb_laser_drive_fault_control
  import laser_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0;
  logic        nrst = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic        pdn = 1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] r;
  logic        pready, pslverr, drv, sen, probe, lit, e;
  logic        s_set = 0;
  logic        s_gnd = 0;
  logic        s_vdd = 0;
  logic        set_gnd, pin_gnd, pin_vdd;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          c;
  always #5 clk = ~clk;
  laser_drive_fault_control dut_u (.SYS_CLK(clk), .NRST(nrst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .POWER_DOWN_N(pdn), .SET_PIN_GND(set_gnd),
    .DRIVE_PIN_GND(pin_gnd), .DRIVE_PIN_VDD(pin_vdd), .DRIVE_CURRENT_OUTPUT(drv),
    .SUPPLY_ENABLE_N(sen), .DETECTOR_PROBE(probe));
  laser_load_model load_u (.drive(drv), .supply_enable_n(sen), .short_set(s_set),
    .short_gnd(s_gnd), .short_vdd(s_vdd), .probe(probe), .set_gnd(set_gnd), .pin_gnd(pin_gnd),
    .pin_vdd(pin_vdd), .lit(lit));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error are taken at the edge that sees ready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cnt(input int n);
    c = 0;
    repeat (n) begin
      @(negedge clk);
      if (drv === 1'b1) c++;
    end
  endtask
  task automatic do_reset;
    nrst <= 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
  endtask
  task automatic stop_test;
    if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
  initial begin
    do_reset();
    apb(1'b0, ADDR_CFG_FLAGS, 32'h0);
    chk(r, {31'h0, MODE_SHUTTER});
    chk(sen, 1'b0);
    apb(1'b0, 8'h18, 32'h0);
    chk(r, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, ADDR_FRAME_PERIOD, 32'h64);
    apb(1'b1, ADDR_ILLUM_CYCLES, 32'h1E);
    repeat (120) @(posedge clk);
    cnt(100);
    chk(c, 30);
    apb(1'b1, ADDR_CFG_FLAGS, {31'h0, MODE_CONTINUOUS});
    repeat (2) @(posedge clk);
    cnt(100);
    chk(c, 100);
    @(posedge clk);
    pdn <= 1'b0;
    cnt(100);
    chk(drv, 1'b1);
    cnt(10100);
    chk(drv, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r[ST_PDOWN_BIT], 1'b1);
    pdn <= 1'b1;
    cnt(6);
    chk(drv, 1'b1);
    apb(1'b1, ADDR_POWER_CFG_HIGH, 32'hA5);
    apb(1'b1, ADDR_POWER_CFG_LOW, 32'h3C);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r[ST_TEST_BIT], 1'b1);
    chk(r[ST_DRIVE_BIT], 1'b0);
    c = 0;
    while (probe !== 1'b1 && c < 100) begin
      @(negedge clk);
      c++;
    end
    chk({probe, drv}, 2'b10);
    repeat (24) @(negedge clk);
    chk(sen, 1'b0);
    apb(1'b0, ADDR_POWER_CFG_LOW, 32'h0);
    chk(r, 32'h3C);
    apb(1'b0, ADDR_POWER_CFG_HIGH, 32'h0);
    chk(r, 32'hA5);
    for (int k = 0; k < 2; k++) begin
      do_reset();
      chk(sen, 1'b0);
      @(posedge clk);
      s_set <= (k == 0);
      s_gnd <= (k == 1);
      cnt(6);
      chk({sen, drv, lit}, 3'b100);
      s_set <= 1'b0;
      s_gnd <= 1'b0;
      cnt(20);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(r[ST_FAULT_BIT], 1'b1);
      chk({sen, drv}, 2'b10);
    end
    do_reset();
    @(posedge clk);
    s_vdd <= 1'b1;
    apb(1'b1, ADDR_POWER_CFG_LOW, 32'h3C);
    repeat (60) @(negedge clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({r[ST_VDD_BIT], r[ST_FAULT_BIT], sen}, 3'b111);
    stop_test();
  end
endmodule
